// [pdc_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Reset low means sleep, gates off with weak pull-down, state reset with masks all ones and reset event latched.
// - Reset high with an enable low gives standby, FETs actively off, SPI alive.
// - Both enables high enter init, low side only; LS then HS toggle enables.
// - Enable mode follows inputs and holds only while both enables and reset high.
// - High side stays off after enable until its low side was commanded on.
// - Desat, phase or supply undervoltage enters fault mode; recovery needs init again.
// - Only the last eight bits of a frame are acted on, for daisy chains.
// - Leading three bits are command, trailing five bits are data.
// - Frame not a nonzero multiple of eight is dropped and flags framing error.
// - First response after reset, and for non-read commands, is status 0.
// - Read command picks status 0 to 3 by low bits and changes nothing.
// - Mask commands load the low nibble into enable group A or B.
// - Group A bits: over-temperature, desat, supply undervoltage, overcurrent.
// - Group B bits: phase error, framing error, write error, reset event.
// - Phase error is comparator XOR drive, blanked, and off in overlap mode.
// - Reset or disable latches reset event, so interrupt rises right after reset.
// - Clear commands clear group A or B latches where the nibble has ones.
// - Faults latch until cleared; interrupt high while any enabled latch set.
// - Clear acts at chip select rise only if frame valid and fault unchanged.
// - Returned flags show all faults uncleared up to the current frame start.
// - Status 0 bits 7..0: reset, write, framing, phase, OC, UV, desat, OT.
// - After mode lock, mask, mode or deadtime writes are refused with write error.
module pdc_ctrl
	import pdc_pkg::*;
(
	// System clock and global reset
	input  wire logic       clk_sys,
	input  wire logic       rstn,
	// Enable and drive command pins
	input  wire logic       enable_input_a,
	input  wire logic       enable_input_b,
	input  wire logic [2:0] low_side_cmd_input,
	input  wire logic [2:0] high_side_cmd_input,
	// Fault detector pins
	input  wire logic       over_temp_in,
	input  wire logic       desat_in,
	input  wire logic       gate_supply_uv_in,
	input  wire logic       overcurrent_in,
	input  wire logic [2:0] phase_cmp_in,
	input  wire logic       desat_blank_in,
	// SPI link
	input  wire logic       spi_sclk,
	input  wire logic       spi_cs_n,
	input  wire logic       spi_mosi,
	output logic            spi_miso,
	output logic            spi_miso_oe_n,
	// Gate drive and status outputs
	output logic [2:0]      gate_hs,
	output logic [2:0]      gate_ls,
	output logic            gate_hold_off,
	output logic            irq,
	output logic [2:0]      mode_state
);
	import pdc_pkg::*;

	localparam int unsigned SYNC_W = 16;

	// Pin synchroniser stages
	logic [SYNC_W-1:0] pin_meta;
	logic [SYNC_W-1:0] pin_sync;
	logic              cs_meta;
	logic              cs_sync;
	logic              cs_last;

	// Synchronised pin views
	logic       en_a;
	logic       en_b;
	logic [2:0] ls_in;
	logic [2:0] hs_in;
	logic       ot_in;
	logic       dsat_in;
	logic       uv_in;
	logic       oc_in;
	logic [2:0] ph_cmp;
	logic       blank_in;

	// Link-side state
	logic       armed;
	logic [7:0] rx_sh;
	logic [2:0] bit_cnt;
	logic       full;
	logic       frame_tog;
	logic       miso_q;
	logic [7:0] next_rx_sh;
	logic [2:0] next_bit_cnt;
	logic       next_full;
	logic       next_frame_tog;

	// Core state
	pdc_mode_e  mode_q;
	pdc_mode_e  next_mode;
	logic [3:0] mask_a;
	logic [3:0] mask_b;
	logic       lock;
	logic       overlap;
	logic       desat_mode;
	logic [7:0] latch;
	logic [7:0] chg;
	logic [7:0] resp;
	logic [1:0] resp_sel;
	logic       tog_seen;
	logic       init_ls;
	logic [2:0] ls_last;
	logic [2:0] hs_last;
	logic [2:0] boot_ok;
	logic [3:0] next_mask_a;
	logic [3:0] next_mask_b;
	logic       next_lock;
	logic       next_overlap;
	logic       next_desat_mode;
	logic [7:0] next_latch;
	logic [7:0] next_chg;
	logic [7:0] next_resp;
	logic [1:0] next_resp_sel;
	logic       next_tog_seen;
	logic       next_init_ls;
	logic [2:0] next_boot_ok;
	logic [2:0] next_gate_hs;
	logic [2:0] next_gate_ls;
	logic       next_hold_off;
	logic       next_irq;

	// Decode helpers
	logic       cs_fall;
	logic       cs_rise;
	logic       frame_bits;
	logic       frame_ok;
	logic [2:0] cmd;
	logic [3:0] nib;
	logic       en_both;
	logic       ph_err;
	logic       prot;
	logic       wr_ev;
	logic       fr_ev;
	logic [7:0] raw;
	logic [7:0] clr;
	logic [7:0] st_sel;

	// Pins cross in through two flops; nothing reads pin_meta but pin_sync
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pin_meta <= '0;
			pin_sync <= '0;
			cs_meta  <= 1'b1;
			cs_sync  <= 1'b1;
			cs_last  <= 1'b1;
		end else begin
			pin_meta <= {enable_input_a, enable_input_b, low_side_cmd_input,
				high_side_cmd_input, over_temp_in, desat_in, gate_supply_uv_in,
				overcurrent_in, phase_cmp_in, desat_blank_in};
			pin_sync <= pin_meta;
			cs_meta  <= spi_cs_n;
			cs_sync  <= cs_meta;
			cs_last  <= cs_sync;
		end
	end

	assign {en_a, en_b, ls_in, hs_in, ot_in, dsat_in, uv_in, oc_in, ph_cmp,
		blank_in} = pin_sync;

	// Frame start marker; the link clock stops between frames, so the
	// chip select itself re-arms it
	always_ff @(posedge spi_sclk or posedge spi_cs_n or negedge rstn) begin
		if (!rstn) begin
			armed <= 1'b1;
		end else if (spi_cs_n) begin
			armed <= 1'b1;
		end else begin
			armed <= 1'b0;
		end
	end

	// Receive shift, bit count and frame toggle on the link clock
	always_comb begin
		next_rx_sh     = {rx_sh[6:0], spi_mosi};
		next_bit_cnt   = armed ? PDC_CNT_ONE : bit_cnt + PDC_CNT_ONE;
		next_full      = armed ? 1'b0 : (full | (bit_cnt == PDC_CNT_LAST));
		next_frame_tog = frame_tog ^ armed;
	end

	always_ff @(posedge spi_sclk or negedge rstn) begin
		if (!rstn) begin
			rx_sh     <= 8'h00;
			bit_cnt   <= PDC_CNT_ZERO;
			full      <= 1'b0;
			frame_tog <= 1'b0;
		end else begin
			rx_sh     <= next_rx_sh;
			bit_cnt   <= next_bit_cnt;
			full      <= next_full;
			frame_tog <= next_frame_tog;
		end
	end

	// Response out on the falling edge; after eight bits pass the input
	// through delayed by one byte so chained parts see their own data
	always_ff @(negedge spi_sclk or negedge rstn) begin
		if (!rstn) begin
			miso_q <= 1'b0;
		end else begin
			miso_q <= full ? rx_sh[7] : resp[~bit_cnt];
		end
	end

	// First bit must stand before any clock edge, hence the bypass
	assign spi_miso = armed ? resp[7] : miso_q;

	// Frame edges and command fields; link words are stable while chip
	// select is high, so they are read only at the synchronised rise
	always_comb begin
		cs_fall    = cs_last & ~cs_sync;
		cs_rise    = ~cs_last & cs_sync;
		frame_bits = frame_tog != tog_seen;
		frame_ok   = frame_bits & full & (bit_cnt == PDC_CNT_ZERO);
		cmd        = rx_sh[7:5];
		nib        = rx_sh[3:0];
		en_both    = en_a & en_b;
	end

	// Fault sources; phase check only where exactly one side is driven
	always_comb begin
		ph_err = (|((ph_cmp ^ gate_hs) & (gate_hs ^ gate_ls)))
			& ~blank_in & ~overlap;
		prot   = uv_in | (~desat_mode & (dsat_in | ph_err));
		fr_ev  = cs_rise & ~frame_ok;
		wr_ev  = 1'b0;
		if (cs_rise && frame_ok) begin
			if (cmd == PDC_CMD_MASK || cmd == PDC_CMD_MODE || cmd == PDC_CMD_DEAD) begin
				wr_ev = lock;
			end else if (cmd != PDC_CMD_NULL && cmd != PDC_CMD_CLR) begin
				wr_ev = 1'b1;
			end
		end
		raw              = 8'h00;
		raw[PDC_F_OT]    = ot_in;
		raw[PDC_F_DESAT] = dsat_in;
		raw[PDC_F_UV]    = uv_in;
		raw[PDC_F_OC]    = oc_in;
		raw[PDC_F_PHASE] = ph_err;
		raw[PDC_F_FRAME] = fr_ev;
		raw[PDC_F_WRITE] = wr_ev;
		raw[PDC_F_RST]   = ~en_both;
	end

	// Latches, masks, mode bits and response selection
	always_comb begin
		clr = 8'h00;
		if (cs_rise && frame_ok && cmd == PDC_CMD_CLR) begin
			clr = rx_sh[PDC_GRP_BIT] ? {nib, PDC_NIB_ZERO}
				: {PDC_NIB_ZERO, nib};
		end
		clr = clr & ~chg;
		// A fault still present re-sets in the same cycle as its clear
		next_latch = (latch & ~clr) | raw;
		next_chg   = cs_fall ? 8'h00 : (chg | (raw & ~latch));
		next_mask_a     = mask_a;
		next_mask_b     = mask_b;
		next_lock       = lock;
		next_overlap    = overlap;
		next_desat_mode = desat_mode;
		next_resp_sel   = resp_sel;
		next_tog_seen   = cs_rise ? frame_tog : tog_seen;
		if (cs_rise && frame_ok) begin
			next_resp_sel = PDC_SEL_ST0;
			case (cmd)
				PDC_CMD_NULL: begin
					next_resp_sel = rx_sh[1:0];
				end
				PDC_CMD_MASK: begin
					if (!lock && !rx_sh[PDC_GRP_BIT]) begin
						next_mask_a = nib;
					end else if (!lock) begin
						next_mask_b = nib;
					end
				end
				PDC_CMD_MODE: begin
					if (!lock) begin
						next_desat_mode = rx_sh[PDC_MODE_DESAT];
						next_overlap    = rx_sh[PDC_MODE_OVL];
						next_lock       = rx_sh[PDC_MODE_LOCK];
					end
				end
				default: begin
					next_resp_sel = PDC_SEL_ST0;
				end
			endcase
		end
		case (resp_sel)
			PDC_SEL_ST1: st_sel = {4'h0, desat_mode, 1'b0, overlap, lock};
			PDC_SEL_ST2: st_sel = {mask_b, mask_a};
			PDC_SEL_ST3: st_sel = {5'h00, mode_q};
			default:     st_sel = latch;
		endcase
		// Snapshot at frame start so the word cannot change mid-shift
		next_resp = cs_fall ? st_sel : resp;
		next_irq  = |(next_latch & {mask_b, mask_a});
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			latch      <= PDC_STAT0_RST;
			chg        <= 8'h00;
			mask_a     <= PDC_MASK_RST;
			mask_b     <= PDC_MASK_RST;
			lock       <= 1'b0;
			overlap    <= 1'b0;
			desat_mode <= 1'b0;
			resp_sel   <= PDC_SEL_ST0;
			resp       <= PDC_STAT0_RST;
			tog_seen   <= 1'b0;
			irq        <= 1'b1;
		end else begin
			latch      <= next_latch;
			chg        <= next_chg;
			mask_a     <= next_mask_a;
			mask_b     <= next_mask_b;
			lock       <= next_lock;
			overlap    <= next_overlap;
			desat_mode <= next_desat_mode;
			resp_sel   <= next_resp_sel;
			resp       <= next_resp;
			tog_seen   <= next_tog_seen;
			irq        <= next_irq;
		end
	end

	// Mode sequencer and gate drive
	always_comb begin
		next_mode = mode_q;
		case (mode_q)
			PDC_SLEEP: begin
				next_mode = PDC_STANDBY;
			end
			PDC_STANDBY: begin
				if (en_both) begin
					next_mode = PDC_INIT;
				end
			end
			PDC_INIT: begin
				if (!en_both) begin
					next_mode = PDC_STANDBY;
				end else if (prot) begin
					next_mode = PDC_FAULT;
				end else if (init_ls && (|(hs_in & ~hs_last))) begin
					next_mode = PDC_ENABLE;
				end
			end
			PDC_ENABLE: begin
				if (!en_both) begin
					next_mode = PDC_STANDBY;
				end else if (prot) begin
					next_mode = PDC_FAULT;
				end
			end
			PDC_FAULT: begin
				if (!en_both) begin
					next_mode = PDC_STANDBY;
				end else if (!prot) begin
					next_mode = PDC_INIT;
				end
			end
			default: begin
				next_mode = PDC_SLEEP;
			end
		endcase
		// Init needs a low-side pulse (high then low) before the high side
		next_init_ls = (mode_q == PDC_INIT)
			? (init_ls | (|(ls_last & ~ls_in))) : 1'b0;
		// Bootstrap charge is assumed once the low side has been commanded on in enable
		next_boot_ok = (mode_q == PDC_ENABLE) ? (boot_ok | ls_in) : 3'h0;
		next_gate_ls = 3'h0;
		next_gate_hs = 3'h0;
		if (mode_q == PDC_INIT) begin
			next_gate_ls = ls_in;
		end else if (mode_q == PDC_ENABLE) begin
			// Both sides on only in overlap mode; otherwise both go off
			next_gate_ls = ls_in & ~(hs_in & ~{3{overlap}});
			next_gate_hs = hs_in & boot_ok & ~(ls_in & ~{3{overlap}});
		end
		// Standby and fault drive gates actively low; pull-down on low supply
		next_hold_off = uv_in;
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			mode_q        <= PDC_SLEEP;
			init_ls       <= 1'b0;
			ls_last       <= 3'h0;
			hs_last       <= 3'h0;
			boot_ok       <= 3'h0;
			gate_hs       <= 3'h0;
			gate_ls       <= 3'h0;
			gate_hold_off <= 1'b1;
			spi_miso_oe_n <= 1'b1;
			mode_state    <= PDC_SLEEP;
		end else begin
			mode_q        <= next_mode;
			init_ls       <= next_init_ls;
			ls_last       <= ls_in;
			hs_last       <= hs_in;
			boot_ok       <= next_boot_ok;
			gate_hs       <= next_gate_hs;
			gate_ls       <= next_gate_ls;
			gate_hold_off <= next_hold_off;
			spi_miso_oe_n <= cs_sync;
			mode_state    <= next_mode;
		end
	end

endmodule
`default_nettype wire

// [pdc_ctrl_props.sv]
`timescale 1ns/1ps
`default_nettype none
module pdc_ctrl_props
	import pdc_pkg::*;
(
	// Clock and reset
	input wire logic       clk_sys,
	input wire logic       rstn,
	// Pins
	input wire logic       enable_input_a,
	input wire logic       enable_input_b,
	input wire logic [2:0] low_side_cmd_input,
	input wire logic [2:0] high_side_cmd_input,
	input wire logic       over_temp_in,
	input wire logic       desat_in,
	input wire logic       gate_supply_uv_in,
	input wire logic       overcurrent_in,
	input wire logic [2:0] phase_cmp_in,
	input wire logic       desat_blank_in,
	// Link
	input wire logic       spi_sclk,
	input wire logic       spi_cs_n,
	input wire logic       spi_mosi,
	input wire logic       spi_miso,
	input wire logic       spi_miso_oe_n,
	// Outputs
	input wire logic [2:0] gate_hs,
	input wire logic [2:0] gate_ls,
	input wire logic       gate_hold_off,
	input wire logic       irq,
	input wire logic [2:0] mode_state
);
	logic [3:0] cs_age;
	logic       cs_q;

	// Age since chip select rose; irq may only drop shortly after a frame
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cs_q   <= 1'b1;
			cs_age <= 4'hF;
		end else begin
			cs_q <= spi_cs_n;
			if (spi_cs_n && !cs_q)
				cs_age <= 4'h0;
			else if (cs_age != 4'hF)
				cs_age <= cs_age + 4'h1;
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	AST_HS_OFF_IDLE: assert property (
		mode_state != PDC_ENABLE && $past(mode_state) != PDC_ENABLE |-> gate_hs == 3'h0)
		else $error("high side on outside enable");
	AST_STBY_LS_OFF: assert property (
		mode_state == PDC_STANDBY && $past(mode_state) == PDC_STANDBY |-> gate_ls == 3'h0)
		else $error("low side on in standby");
	AST_DISABLED_STBY: assert property (
		(!enable_input_a || !enable_input_b) [*6] |-> mode_state == PDC_STANDBY)
		else $error("not standby while disabled");
	AST_INIT_ENTRY: assert property (
		$rose(enable_input_a && enable_input_b) && !gate_supply_uv_in
		|-> ##[2:5] mode_state == PDC_INIT)
		else $error("init not entered");
	AST_UV_FAULT: assert property (
		gate_supply_uv_in [*5] |-> mode_state != PDC_ENABLE && mode_state != PDC_INIT)
		else $error("driving under low supply");
	AST_UV_HOLDOFF: assert property (
		gate_supply_uv_in [*4] |-> gate_hold_off)
		else $error("no hold off under low supply");
	AST_IRQ_AFTER_RESET: assert property (
		!$past(rstn) |-> irq)
		else $error("irq low after reset");
	AST_IRQ_FALL_CAUSE: assert property (
		$fell(irq) |-> cs_age < 4'hA)
		else $error("irq dropped without command");
	AST_MISO_RELEASE: assert property (
		spi_cs_n [*5] |-> spi_miso_oe_n)
		else $error("miso driven while deselected");
endmodule

bind pdc_ctrl pdc_ctrl_props pdc_ctrl_props_inst (
	.clk_sys, .rstn, .enable_input_a, .enable_input_b,
	.low_side_cmd_input, .high_side_cmd_input, .over_temp_in,
	.desat_in, .gate_supply_uv_in, .overcurrent_in, .phase_cmp_in,
	.desat_blank_in, .spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso,
	.spi_miso_oe_n, .gate_hs, .gate_ls, .gate_hold_off, .irq, .mode_state
);
`default_nettype wire

// [pdc_ctrl_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module pdc_ctrl_tb;
	import pdc_pkg::*;
	logic       clk_sys;
	logic       rstn;
	logic       enable_input_a;
	logic       enable_input_b;
	logic [2:0] low_side_cmd_input;
	logic [2:0] high_side_cmd_input;
	logic       over_temp_in;
	logic       desat_in;
	logic       gate_supply_uv_in;
	logic       overcurrent_in;
	logic [2:0] phase_cmp_in;
	logic       desat_blank_in;
	logic       spi_sclk;
	logic       spi_cs_n;
	logic       spi_mosi;
	logic       spi_miso;
	logic       spi_miso_oe_n;
	logic [2:0] gate_hs;
	logic [2:0] gate_ls;
	logic       gate_hold_off;
	logic       irq;
	logic [2:0] mode_state;
	logic [7:0] rx;
	int         err_total;
	int         samples_checked;
	int         cycles;

	pdc_ctrl pdc_ctrl_inst (
		.clk_sys, .rstn, .enable_input_a, .enable_input_b,
		.low_side_cmd_input, .high_side_cmd_input, .over_temp_in,
		.desat_in, .gate_supply_uv_in, .overcurrent_in, .phase_cmp_in,
		.desat_blank_in, .spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso,
		.spi_miso_oe_n, .gate_hs, .gate_ls, .gate_hold_off, .irq, .mode_state
	);

	pdc_spi_host pdc_spi_host_inst (.spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso);

	// System clock
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic final_report;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Hang guard, far above the expected run length
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 8000) begin
			err_total++;
			final_report;
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask

	// Byte frame; the reply reflects the previous command's selector
	task automatic f(input logic [7:0] tx, input logic [7:0] exp);
		pdc_spi_host_inst.xfer({8'h00, tx}, 8, rx);
		chk(rx, exp);
	endtask

	// Falling edge keeps drives and samples away from the active edge
	task automatic w(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	initial begin
		{rstn, enable_input_a, enable_input_b, over_temp_in, desat_in} = 5'h00;
		{gate_supply_uv_in, overcurrent_in, low_side_cmd_input} = 5'h00;
		high_side_cmd_input = 3'h0;
		phase_cmp_in = 3'h0;
		desat_blank_in = 1'b1; // Keeps phase checks out of the gate tests
		w(6);
		chk(8'(mode_state), 8'(PDC_SLEEP));
		chk({gate_hs, gate_ls, gate_hold_off, irq}, 8'h03);
		rstn <= 1'b1;
		w(3);
		chk(8'(mode_state), 8'(PDC_STANDBY));
		chk(8'(irq), 8'h01);
		$display("reset test done");
		f(8'h02, PDC_STAT0_RST);
		f(8'h20, 8'hFF);
		f(8'h37, 8'h80);
		chk(8'(irq), 8'h00);
		f(8'h02, 8'h80);
		f(8'h00, 8'h70);
		pdc_spi_host_inst.xfer(16'h001F, 5, rx);
		chk(8'(irq), 8'h01);
		f(8'h72, 8'hA0);
		f(8'h00, 8'h80);
		chk(8'(irq), 8'h00);
		pdc_spi_host_inst.xfer(16'h3F02, 16, rx);
		f(8'h00, 8'h70);
		$display("command test done");
		f(8'h21, 8'h80);
		w(1);
		over_temp_in <= 1'b1;
		w(6);
		chk(8'(irq), 8'h01);
		f(8'h61, 8'h81);
		f(8'h00, 8'h81);
		w(1);
		over_temp_in <= 1'b0;
		w(6);
		chk(8'(irq), 8'h01);
		f(8'h61, 8'h81);
		f(8'h00, 8'h80);
		chk(8'(irq), 8'h00);
		f(8'h41, 8'h80);
		f(8'h2F, 8'h80);
		f(8'h02, 8'hC0);
		chk(8'(irq), 8'h01);
		f(8'h74, 8'h71);
		f(8'h01, 8'h80);
		f(8'h03, 8'h01);
		f(8'h00, 8'h01);
		overcurrent_in <= 1'b1; // Masked off in group A, so no interrupt
		w(6);
		chk(8'(irq), 8'h00);
		f(8'h00, 8'h88);
		overcurrent_in <= 1'b0;
		$display("fault test done");
		w(1);
		enable_input_a <= 1'b1;
		enable_input_b <= 1'b1;
		w(6);
		chk(8'(mode_state), 8'(PDC_INIT));
		low_side_cmd_input <= 3'h1;
		w(6);
		chk({2'h0, gate_hs, gate_ls}, 8'h01);
		low_side_cmd_input <= 3'h0;
		w(6);
		high_side_cmd_input <= 3'h1;
		w(6);
		chk(8'(mode_state), 8'(PDC_ENABLE));
		chk({2'h0, gate_hs, gate_ls}, 8'h00);
		high_side_cmd_input <= 3'h0;
		low_side_cmd_input <= 3'h1; // Bootstrap charge pulse first
		w(6);
		low_side_cmd_input <= 3'h0;
		w(6);
		high_side_cmd_input <= 3'h1;
		w(6);
		chk({2'h0, gate_hs, gate_ls}, 8'h08);
		desat_blank_in <= 1'b0; // Node stays low under a driven high side
		w(6);
		chk(8'(mode_state), 8'(PDC_INIT));
		chk({2'h0, gate_hs, gate_ls}, 8'h00);
		desat_blank_in <= 1'b1;
		enable_input_b <= 1'b0;
		w(6);
		chk(8'(mode_state), 8'(PDC_STANDBY));
		chk({2'h0, gate_hs, gate_ls}, 8'h00);
		high_side_cmd_input <= 3'h0;
		enable_input_b <= 1'b1;
		w(6);
		gate_supply_uv_in <= 1'b1;
		w(6);
		chk(8'(mode_state), 8'(PDC_FAULT));
		chk(8'(gate_hold_off), 8'h01);
		gate_supply_uv_in <= 1'b0;
		w(6);
		chk(8'(mode_state), 8'(PDC_INIT));
		$display("mode test done");
		rstn <= 1'b0;
		w(2);
		chk(8'(mode_state), 8'(PDC_SLEEP));
		chk(8'(irq), 8'h01);
		rstn <= 1'b1;
		w(3);
		f(8'h00, 8'h80);
		$display("second reset test done");
		final_report;
	end
endmodule
`default_nettype wire

// [pdc_pkg.sv]
`default_nettype none
package pdc_pkg;

	// Operating modes, Gray coded along sleep, standby, init, enable, fault
	typedef enum logic [2:0] {
		PDC_SLEEP   = 3'h0,
		PDC_STANDBY = 3'h1,
		PDC_INIT    = 3'h3,
		PDC_ENABLE  = 3'h2,
		PDC_FAULT   = 3'h6
	} pdc_mode_e;

	// Frame geometry
	localparam int unsigned PDC_SPI_BITS = 8;
	localparam logic [2:0]  PDC_CNT_ZERO = 3'h0;
	localparam logic [2:0]  PDC_CNT_ONE  = 3'h1;
	localparam logic [2:0]  PDC_CNT_LAST = 3'h7;

	// Command prefixes (leading three bits) and group select bit
	localparam logic [2:0] PDC_CMD_NULL = 3'h0;
	localparam logic [2:0] PDC_CMD_MASK = 3'h1;
	localparam logic [2:0] PDC_CMD_MODE = 3'h2;
	localparam logic [2:0] PDC_CMD_CLR  = 3'h3;
	localparam logic [2:0] PDC_CMD_DEAD = 3'h4;
	localparam int unsigned PDC_GRP_BIT = 4;

	// Mode command fields
	localparam int unsigned PDC_MODE_LOCK  = 0;
	localparam int unsigned PDC_MODE_OVL   = 1;
	localparam int unsigned PDC_MODE_DESAT = 3;

	// Status register 0 flag positions
	localparam int unsigned PDC_F_OT    = 0;
	localparam int unsigned PDC_F_DESAT = 1;
	localparam int unsigned PDC_F_UV    = 2;
	localparam int unsigned PDC_F_OC    = 3;
	localparam int unsigned PDC_F_PHASE = 4;
	localparam int unsigned PDC_F_FRAME = 5;
	localparam int unsigned PDC_F_WRITE = 6;
	localparam int unsigned PDC_F_RST   = 7;

	// Status read selectors
	localparam logic [1:0] PDC_SEL_ST0 = 2'h0;
	localparam logic [1:0] PDC_SEL_ST1 = 2'h1;
	localparam logic [1:0] PDC_SEL_ST2 = 2'h2;
	localparam logic [1:0] PDC_SEL_ST3 = 2'h3;

	// Reset values
	localparam logic [3:0] PDC_MASK_RST  = 4'hF;
	localparam logic [7:0] PDC_STAT0_RST = 8'h80;
	localparam logic [3:0] PDC_NIB_ZERO  = 4'h0;

endpackage
`default_nettype wire

// [pdc_spi_host.sv]
`timescale 1ns/1ps
`default_nettype none
module pdc_spi_host (
	// Link pins
	output logic      spi_sclk,
	output logic      spi_cs_n,
	output logic      spi_mosi,
	input wire logic  spi_miso
);
	initial begin
		spi_sclk = 1'b0;
		spi_cs_n = 1'b1;
		spi_mosi = 1'b0;
	end

	// One frame, MSB first; clock only runs inside the frame
	task automatic xfer(input logic [15:0] tx, input int n, output logic [7:0] rx);
		rx = 8'h00;
		#3 spi_cs_n = 1'b0;
		#60;
		for (int i = n - 1; i >= 0; i--) begin
			spi_mosi = tx[i];
			// Take the reply bit before the rising edge moves the output mux
			#16 rx = {rx[6:0], spi_miso};
			spi_sclk = 1'b1;
			#16 spi_sclk = 1'b0;
		end
		#20 spi_cs_n = 1'b1;
		spi_mosi = ~spi_mosi; // No stale bit once released
		#80; // Gap well over the minimum deselect time
	endtask
endmodule
`default_nettype wire
